//--- common/bor_pkg.sv
// package for the brown-out reset controller: field positions, reset values,
// mode encodings, timing constants and the carrier structs.
// assumes a 10 MHz system clock; nothing else is needed from the surroundings.
package bor_pkg;

  // ---------------------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned PWRUP_DELAY_MS  = 64;
  localparam int unsigned PWRUP_DELAY_CYC = (CLK_HZ / 1000) * PWRUP_DELAY_MS;

  // ---------------------------------------------------------------------------
  // power configuration word fields
  // ---------------------------------------------------------------------------
  localparam int unsigned CFG_MODE_LSB   = 0;   // enable mode, bits 1:0
  localparam int unsigned CFG_THRESH_LSB = 5;   // threshold select, bits 6:5

  typedef enum logic [1:0] {
    MODE_OFF      = 2'h0,
    MODE_SOFTWARE = 2'h1,
    MODE_NO_SLEEP = 2'h2,
    MODE_ALWAYS   = 2'h3
  } bor_mode_e;

  localparam logic [1:0] THRESH_LOW_POWER = 2'h0;

  // ---------------------------------------------------------------------------
  // reset cause register bits
  // ---------------------------------------------------------------------------
  localparam int unsigned RC_POR    = 0;
  localparam int unsigned RC_BOR    = 1;
  localparam int unsigned RC_SOFT_BROWNOUT_ENABLE = 13;
  localparam logic [15:0] RC_IMPL_MASK = 16'hE3FF; // bits 12:10 unimplemented
  localparam logic [15:0] RC_POR_VAL   = 16'h0003;

  // ---------------------------------------------------------------------------
  // reset values of the other registers that depend on reset type
  // ---------------------------------------------------------------------------
  localparam logic [15:0] RTC_CAL_RESET = 16'h0000;
  localparam logic [15:0] NVM_CTL_RESET = 16'h0000;
  localparam logic [2:0]  OSC_SEL_RESET = 3'h0;
  localparam int unsigned OSC_CUR_LSB   = 12;  // current osc bits 14:12
  localparam logic [23:0] RESET_VECTOR  = 24'h000000;

  // ---------------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic        wr_reset_cause_register;
    logic [15:0] reset_cause_register_wdata;
    logic        wr_rtc_cal;
    logic [15:0] rtc_cal_wdata;
    logic        wr_nvm_ctl;
    logic [15:0] nvm_ctl_wdata;
    logic        wr_osc;
    logic [2:0]  osc_wdata;
  } core_wr_s;

  typedef struct packed {
    logic [15:0] reset_cause_register;
    logic [15:0] rtc_cal;
    logic [15:0] nvm_ctl;
    logic [15:0] osc_ctl;
  } core_rd_s;

endpackage

//--- rtl/pwrup_timer.sv
// power-up delay counter: holds done low until the delay has run out.
// assumes run is a level that stays high while the delay should run.
`timescale 1ns/1ps
`default_nettype none

module pwrup_timer #(
  parameter int unsigned DELAY_CYC = bor_pkg::PWRUP_DELAY_CYC
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic run,
  output logic      done
);

  localparam int unsigned CW = $clog2(DELAY_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(DELAY_CYC - 1);

  logic [CW-1:0] count;

  // -------------------------------------------------------------------------
  // counter
  // -------------------------------------------------------------------------
  // dropping run reinitialises, so a fresh dip restarts the whole delay
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
      done  <= 1'b0;
    end else if (!run) begin
      count <= '0;
      done  <= 1'b0;
    end else if (!done) begin
      if (count == LAST) begin
        done <= 1'b1;
      end
      count <= count + CW'(1);
    end
  end

endmodule

`default_nettype wire

//--- rtl/brownout_reset_control.sv
// brown-out reset controller: mode select, sync of the supply detector,
// power-up delay, reset-cause flags and reset-type dependent register values.
// assumes the analog detector gives a level, config words are static, and
// nrst is the power-on reset of the digital core.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - other registers reset alike regardless of type
// - cause register value reflects the reset kind
// - oscillator reset value from type and config
// - calibration and nvm control reset only on POR
// - two 2-bit config fields select behaviour
// - enabled mode holds reset while supply low
// - delay runs after recovery, restarts on dip
// - delay enable independent of brown-out enable
// - threshold 00 re-arms POR, no reset
// - mode 01 follows software enable bit
// - software bit reads zero outside mode 01
// - threshold from config only, never software
// - brown-out flag set on brown-out or POR
// - leaving deep sleep sets both flags
// - mode 10 disables detection during sleep
// - any reset forces program counter to zero
// - delay is 64 ms when enabled, else none
// - software bit forced zero, resets to one
module brownout_reset_control #(
  parameter int unsigned PWRUP_CYC = bor_pkg::PWRUP_DELAY_CYC
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [7:0]        power_config_word,
  input  wire logic [2:0]        new_osc_select_bits,
  input  wire logic              clock_switch_enable,
  input  wire logic              power_up_timer_enable,
  input  wire logic              supply_below_threshold,
  input  wire logic              sleep_mode,
  input  wire logic              deep_sleep_exit,
  input  wire logic              other_reset,
  input  wire bor_pkg::core_wr_s core_wr,
  output bor_pkg::core_rd_s      core_rd,
  output logic [1:0]             detector_threshold,
  output logic                   detector_enable,
  output logic                   por_rearm,
  output logic                   system_reset,
  output logic [23:0]            program_counter_init
);

  // -------------------------------------------------------------------------
  // configuration decode
  // -------------------------------------------------------------------------
  bor_pkg::bor_mode_e mode;
  logic [1:0]         thresh;
  logic               soft_brownout_enable;
  logic               low_power_brownout_mode;

  assign mode   = bor_pkg::bor_mode_e'(power_config_word[bor_pkg::CFG_MODE_LSB +: 2]);
  assign thresh = power_config_word[bor_pkg::CFG_THRESH_LSB +: 2];
  assign low_power_brownout_mode = (thresh == bor_pkg::THRESH_LOW_POWER);
  // threshold goes straight from config to the detector; no write path
  assign detector_threshold = thresh;

  // detection enable per mode
  always_comb begin
    case (mode)
      bor_pkg::MODE_OFF:      detector_enable = 1'b0;
      bor_pkg::MODE_SOFTWARE: detector_enable = soft_brownout_enable;
      bor_pkg::MODE_NO_SLEEP: detector_enable = !sleep_mode;
      bor_pkg::MODE_ALWAYS:   detector_enable = 1'b1;
      default:                detector_enable = 1'b0;
    endcase
  end

  // -------------------------------------------------------------------------
  // detector synchroniser
  // -------------------------------------------------------------------------
  logic sync_a;
  logic sync_b;

  // first stage is read by the second stage only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= supply_below_threshold;
      sync_b <= sync_a;
    end
  end

  logic brownout_low;
  // low-power setting never resets; it only re-arms the POR detector
  assign brownout_low = detector_enable && sync_b && !low_power_brownout_mode;
  assign por_rearm    = detector_enable && sync_b && low_power_brownout_mode;

  // -------------------------------------------------------------------------
  // reset sequencer
  // -------------------------------------------------------------------------
  // gray along the recovery path hold, delay, run; a dip from run and the undelayed hold to run jump two bits
  typedef enum logic [1:0] {
    ST_RUN   = 2'h2,
    ST_HOLD  = 2'h1,
    ST_DELAY = 2'h3
  } seq_e;

  seq_e seq;
  seq_e next_seq;
  logic delay_done;
  logic bor_event;

  pwrup_timer #(
    .DELAY_CYC (PWRUP_CYC)
  ) u_timer (
    .clk  (clk),
    .nrst (nrst),
    .run  (seq == ST_DELAY),
    .done (delay_done)
  );

  // a dip in any state falls back to hold; delay state only when enabled
  always_comb begin
    next_seq = seq;
    case (seq)
      ST_RUN: begin
        if (brownout_low) next_seq = ST_HOLD;
      end
      ST_HOLD: begin
        if (!brownout_low) begin
          next_seq = power_up_timer_enable ? ST_DELAY : ST_RUN;
        end
      end
      ST_DELAY: begin
        if (brownout_low) next_seq = ST_HOLD;
        else if (delay_done) next_seq = ST_RUN;
      end
      default: next_seq = ST_HOLD;
    endcase
  end

  // after power-on the chip also passes the delay when it is enabled
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seq <= ST_HOLD;
    end else begin
      seq <= next_seq;
    end
  end

  assign bor_event    = (seq == ST_RUN) && brownout_low;
  assign system_reset = (seq != ST_RUN) || other_reset;

  // execution always starts at the reset address
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      program_counter_init <= bor_pkg::RESET_VECTOR;
    end else if (system_reset) begin
      program_counter_init <= bor_pkg::RESET_VECTOR;
    end
  end

  // -------------------------------------------------------------------------
  // reset cause register
  // -------------------------------------------------------------------------
  logic [15:0] reset_cause_register;
  logic        soft_rst_val;
  logic [15:0] wmask;

  assign soft_rst_val = (mode == bor_pkg::MODE_SOFTWARE);
  assign wmask        = bor_pkg::RC_IMPL_MASK;

  // hardware set wins over a software write in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reset_cause_register <= bor_pkg::RC_POR_VAL;
    end else begin
      if (core_wr.wr_reset_cause_register) begin
        reset_cause_register <= core_wr.reset_cause_register_wdata & wmask;
      end
      if (bor_event) begin
        reset_cause_register[bor_pkg::RC_BOR] <= 1'b1;
      end
      if (deep_sleep_exit) begin
        reset_cause_register[bor_pkg::RC_POR] <= 1'b1;
        reset_cause_register[bor_pkg::RC_BOR] <= 1'b1;
      end
    end
  end

  // software enable bit: forced low outside mode 01, resets to one in it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      soft_brownout_enable <= 1'b0;
    end else if (mode != bor_pkg::MODE_SOFTWARE) begin
      soft_brownout_enable <= 1'b0;
    end else if (seq == ST_HOLD && !brownout_low && !soft_brownout_enable
                 && reset_cause_register[bor_pkg::RC_POR]) begin
      soft_brownout_enable <= soft_rst_val;
    end else if (core_wr.wr_reset_cause_register) begin
      soft_brownout_enable <= core_wr.reset_cause_register_wdata[bor_pkg::RC_SOFT_BROWNOUT_ENABLE];
    end
  end

  // -------------------------------------------------------------------------
  // reset-type dependent registers
  // -------------------------------------------------------------------------
  logic [15:0] rtc_cal;
  logic [15:0] nvm_ctl;
  logic [2:0]  osc_cur;

  // calibration and nvm control ignore every reset but power-on
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rtc_cal <= bor_pkg::RTC_CAL_RESET;
      nvm_ctl <= bor_pkg::NVM_CTL_RESET;
    end else begin
      if (core_wr.wr_rtc_cal) rtc_cal <= core_wr.rtc_cal_wdata;
      if (core_wr.wr_nvm_ctl) nvm_ctl <= core_wr.nvm_ctl_wdata;
    end
  end

  // oscillator: config bits after POR/BOR or with switching off, else keep the live selection
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      osc_cur <= bor_pkg::OSC_SEL_RESET;
    end else if (seq == ST_HOLD || !clock_switch_enable) begin
      osc_cur <= new_osc_select_bits;
    end else if (core_wr.wr_osc && !system_reset) begin
      osc_cur <= core_wr.osc_wdata;
    end
  end

  // read-back; software bit comes from its own flop so it reads 0 off-mode
  always_comb begin
    core_rd.reset_cause_register = reset_cause_register & ~(16'h1 << bor_pkg::RC_SOFT_BROWNOUT_ENABLE);
    core_rd.reset_cause_register[bor_pkg::RC_SOFT_BROWNOUT_ENABLE] = soft_brownout_enable;
    core_rd.rtc_cal = rtc_cal;
    core_rd.nvm_ctl = nvm_ctl;
    core_rd.osc_ctl = 16'h0000;
    core_rd.osc_ctl[bor_pkg::OSC_CUR_LSB +: 3] = osc_cur;
  end
  // all other special registers belong to their own blocks and reset alike
  // on system_reset, whatever its cause

  // -------------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------------
  property p_hold_low;
    @(posedge clk) disable iff (!nrst)
      brownout_low |=> system_reset;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("no reset on dip");

  property p_lp_no_reset;
    @(posedge clk) disable iff (!nrst)
      (seq == ST_RUN && low_power_brownout_mode && !other_reset) |=> seq == ST_RUN;
  endproperty
  a_lp_no_reset: assert property (p_lp_no_reset) else $error("low power reset");

  property p_soft_zero;
    @(posedge clk) disable iff (!nrst)
      (mode != bor_pkg::MODE_SOFTWARE) |=> !core_rd.reset_cause_register[bor_pkg::RC_SOFT_BROWNOUT_ENABLE] || $changed(mode);
  endproperty
  a_soft_zero: assert property (p_soft_zero) else $error("soft bit not zero");

  property p_sleep_off;
    @(posedge clk) disable iff (!nrst)
      (mode == bor_pkg::MODE_NO_SLEEP && sleep_mode) |-> !detector_enable;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("enabled in sleep");

  property p_bor_flag;
    @(posedge clk) disable iff (!nrst)
      bor_event |=> reset_cause_register[bor_pkg::RC_BOR];
  endproperty
  a_bor_flag: assert property (p_bor_flag) else $error("flag not set");

  property p_deep_exit;
    @(posedge clk) disable iff (!nrst)
      deep_sleep_exit |=> reset_cause_register[bor_pkg::RC_POR] && reset_cause_register[bor_pkg::RC_BOR];
  endproperty
  a_deep_exit: assert property (p_deep_exit) else $error("deep exit flags");

  property p_sync;
    @(posedge clk) disable iff (!nrst)
      supply_below_threshold |-> ##2 sync_b == $past(supply_below_threshold, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("sync latency");

  property p_no_delay;
    @(posedge clk) disable iff (!nrst)
      (seq == ST_HOLD && !brownout_low && !power_up_timer_enable) |=> seq == ST_RUN;
  endproperty
  a_no_delay: assert property (p_no_delay) else $error("delay when off");

  property p_pc_zero;
    @(posedge clk) disable iff (!nrst)
      system_reset |=> program_counter_init == bor_pkg::RESET_VECTOR;
  endproperty
  a_pc_zero: assert property (p_pc_zero) else $error("pc not zero");

  property p_mode_off;
    @(posedge clk) disable iff (!nrst)
      (mode == bor_pkg::MODE_OFF) |-> !detector_enable && !por_rearm;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("off mode active");

  // calibration and nvm control move only on their own writes, never on a
  // brown-out or other reset
  property p_por_only;
    @(posedge clk) disable iff (!nrst)
      (!core_wr.wr_rtc_cal && !core_wr.wr_nvm_ctl)
        |=> $stable(rtc_cal) && $stable(nvm_ctl);
  endproperty
  a_por_only: assert property (p_por_only) else $error("calibration lost");

  // with switching on, a reset other than POR or brown-out keeps the live selection
  property p_osc_keep;
    @(posedge clk) disable iff (!nrst)
      (clock_switch_enable && seq == ST_RUN && !core_wr.wr_osc) |=> $stable(osc_cur);
  endproperty
  a_osc_keep: assert property (p_osc_keep) else $error("osc selection lost");

  // software mode: the enable bit comes back as one after power-on
  property p_soft_one;
    @(posedge clk) disable iff (!nrst)
      (mode == bor_pkg::MODE_SOFTWARE && seq == ST_HOLD && !brownout_low
       && reset_cause_register[bor_pkg::RC_POR] && !core_wr.wr_reset_cause_register) |=> soft_brownout_enable;
  endproperty
  a_soft_one: assert property (p_soft_one) else $error("soft bit not one");

  // a dip during the delay goes back to hold and clears the timer
  property p_delay_restart;
    @(posedge clk) disable iff (!nrst)
      (seq == ST_DELAY && brownout_low) |=> (seq == ST_HOLD) ##1 !delay_done;
  endproperty
  a_delay_restart: assert property (p_delay_restart) else $error("delay not restarted");

  c_bor: cover property (@(posedge clk) disable iff (!nrst) bor_event);
  c_delay: cover property (@(posedge clk) disable iff (!nrst) seq == ST_DELAY ##1 seq == ST_HOLD);
  c_rearm: cover property (@(posedge clk) disable iff (!nrst) por_rearm);
  c_deep: cover property (@(posedge clk) disable iff (!nrst) deep_sleep_exit);
  c_soft: cover property (@(posedge clk) disable iff (!nrst) soft_brownout_enable);

endmodule

`default_nettype wire

//--- verification/supply_model.sv
// supply voltage detector model: turns a commanded supply dip into the
// analog comparator level. assumes the bench drives drop off the rising edge.
`timescale 1ns/1ps
`default_nettype none

module supply_model #(
  parameter int LAG = 2
) (
  input  wire logic clk,
  input  wire logic drop,
  output logic      supply_below_threshold
);
  logic [7:0] line = 8'h00;

  // ---------------------------------------------------------------------------
  // comparator lag
  // ---------------------------------------------------------------------------
  // the analog output trails the supply; a lag above 1 shows a slow detector
  always @(posedge clk) begin
    line <= {line[6:0], drop};
  end
  assign supply_below_threshold = line[LAG-1];
endmodule
`default_nettype wire

//--- verification/test_brownout_reset_control.sv
// self-checking bench for the brown-out reset controller.
// assumes bor_pkg, the design files and supply_model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module test_brownout_reset_control;
  localparam int DLY = 20;
  logic              clk = 1'b0;
  logic              nrst = 1'b0;
  logic [7:0]        power_config_word = 8'h23;
  logic [2:0]        new_osc_select_bits = 3'h5;
  logic              clock_switch_enable = 1'b0;
  logic              power_up_timer_enable = 1'b1;
  logic              drop = 1'b0;
  logic              supply_below_threshold;
  logic              sleep_mode = 1'b0;
  logic              deep_sleep_exit = 1'b0;
  logic              other_reset = 1'b0;
  bor_pkg::core_wr_s core_wr = '0;
  bor_pkg::core_rd_s core_rd;
  logic [1:0]        detector_threshold;
  logic              detector_enable;
  logic              por_rearm;
  logic              system_reset;
  logic [23:0]       program_counter_init;
  int                failures = 0;
  int                n_tests = 0;
  int                n;

  // ---------------------------------------------------------------------------
  // clock, partner and design
  // ---------------------------------------------------------------------------
  initial begin
    forever #50 clk = ~clk;
  end
  supply_model #(.LAG(2)) model (.clk, .drop, .supply_below_threshold);
  brownout_reset_control #(.PWRUP_CYC(DLY)) dut (.clk, .nrst, .power_config_word,
    .new_osc_select_bits, .clock_switch_enable, .power_up_timer_enable,
    .supply_below_threshold, .sleep_mode, .deep_sleep_exit, .other_reset, .core_wr,
    .core_rd, .detector_threshold, .detector_enable, .por_rearm, .system_reset,
    .program_counter_init);

  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  task automatic finish_test();
    if (failures == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  // bounded wait for the reset output; a hang counts and ends the run
  task automatic wait_rst(input logic lvl, input int lim, output int k);
    k = 0;
    while (system_reset !== lvl) begin
      if (k == lim) begin
        failures++;
        finish_test();
      end
      cyc(1);
      k++;
    end
  endtask

  // strobe held over one rising edge, then a quiet edge so calls never abut
  task automatic wr_reset_cause_register(input logic [15:0] d);
    core_wr.wr_reset_cause_register = 1'b1;
    core_wr.reset_cause_register_wdata = d;
    cyc(1);
    core_wr.wr_reset_cause_register = 1'b0;
    cyc(1);
  endtask

  // power-on with a new configuration; config only changes while held
  task automatic boot(input logic [7:0] cfg, input logic tmr);
    nrst = 1'b0;
    power_config_word = cfg;
    power_up_timer_enable = tmr;
    cyc(6);
    nrst = 1'b1;
    wait_rst(1'b0, 40, n);
  endtask

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  // power-on values, then what survives a non power-on reset
  task automatic t_reset_values();
    boot(8'h21, 1'b1);
    chk("reset_cause_register", core_rd.reset_cause_register, 16'h2003);
    chk("rtc", core_rd.rtc_cal, 16'h0000);
    chk("nvm", core_rd.nvm_ctl, 16'h0000);
    chk("osc", core_rd.osc_ctl[14:12], 3'h5);
    chk("thr", detector_threshold, 2'h1);
    core_wr.wr_rtc_cal = 1'b1;
    core_wr.rtc_cal_wdata = 16'h0055;
    core_wr.wr_nvm_ctl = 1'b1;
    core_wr.nvm_ctl_wdata = 16'h0044;
    core_wr.wr_osc = 1'b1;
    core_wr.osc_wdata = 3'h2;
    cyc(1);
    core_wr = '0;
    cyc(1);
    // switching disabled, so the config selection must win over the write
    chk("osc", core_rd.osc_ctl[14:12], 3'h5);
    other_reset = 1'b1;
    cyc(3);
    other_reset = 1'b0;
    wait_rst(1'b0, 40, n);
    chk("rtc", core_rd.rtc_cal, 16'h0055);
    chk("nvm", core_rd.nvm_ctl, 16'h0044);
    chk("pc", program_counter_init, 24'h000000);
    // switching on: the live selection survives other_reset but not a brown-out
    clock_switch_enable = 1'b1;
    core_wr.wr_osc = 1'b1;
    core_wr.osc_wdata = 3'h2;
    cyc(1);
    core_wr = '0;
    cyc(1);
    chk("osc", core_rd.osc_ctl[14:12], 3'h2);
    other_reset = 1'b1;
    cyc(3);
    other_reset = 1'b0;
    cyc(1);
    chk("osc", core_rd.osc_ctl[14:12], 3'h2);
    drop = 1'b1;
    wait_rst(1'b1, 8, n);
    drop = 1'b0;
    wait_rst(1'b0, 40, n);
    chk("osc", core_rd.osc_ctl[14:12], 3'h5);
    nrst = 1'b0;
    cyc(1);
    chk("rtc", core_rd.rtc_cal, 16'h0000);
    nrst = 1'b1;
    wait_rst(1'b0, 40, n);
  endtask

  // software enable bit gates detection only in mode 01
  task automatic t_soft_mode();
    wr_reset_cause_register(16'h0000);
    chk("en", detector_enable, 1'b0);
    drop = 1'b1;
    cyc(8);
    chk("rst", system_reset, 1'b0);
    drop = 1'b0;
    cyc(4);
    wr_reset_cause_register(16'h3C00);
    chk("reset_cause_register", core_rd.reset_cause_register, 16'h2000);
    chk("en", detector_enable, 1'b1);
    boot(8'h23, 1'b1);
    chk("reset_cause_register", core_rd.reset_cause_register, 16'h0003);
    wr_reset_cause_register(16'h2000);
    chk("reset_cause_register", core_rd.reset_cause_register, 16'h0000);
  endtask

  // dip, hold, recovery delay, and a second dip while the delay runs
  task automatic t_bor_delay();
    wr_reset_cause_register(16'h0000);
    drop = 1'b1;
    wait_rst(1'b1, 8, n);
    chk("reset_cause_register", core_rd.reset_cause_register, 16'h0002);
    cyc(30);
    chk("rst", system_reset, 1'b1);
    drop = 1'b0;
    cyc(10);
    chk("rst", system_reset, 1'b1);
    drop = 1'b1;
    cyc(6);
    drop = 1'b0;
    wait_rst(1'b0, 40, n);
    chk("delay", n >= DLY && n <= DLY + 6, 1'b1);
    boot(8'h23, 1'b0);
    drop = 1'b1;
    wait_rst(1'b1, 8, n);
    drop = 1'b0;
    wait_rst(1'b0, 40, n);
    chk("delay", n <= 6, 1'b1);
  endtask

  // sleep turns detection off in mode 10 but not in mode 11
  task automatic t_sleep();
    boot(8'h22, 1'b1);
    chk("en", detector_enable, 1'b1);
    sleep_mode = 1'b1;
    drop = 1'b1;
    cyc(8);
    chk("en", detector_enable, 1'b0);
    chk("rst", system_reset, 1'b0);
    // supply back and settled through the detector before waking
    drop = 1'b0;
    cyc(4);
    sleep_mode = 1'b0;
    cyc(1);
    chk("en", detector_enable, 1'b1);
    chk("rst", system_reset, 1'b0);
    boot(8'h23, 1'b1);
    sleep_mode = 1'b1;
    drop = 1'b1;
    wait_rst(1'b1, 8, n);
    chk("en", detector_enable, 1'b1);
    drop = 1'b0;
    sleep_mode = 1'b0;
    wait_rst(1'b0, 40, n);
  endtask

  // low-power threshold never resets; deep sleep exit sets both flags
  task automatic t_low_power();
    boot(8'h03, 1'b1);
    wr_reset_cause_register(16'hFFFF);
    chk("thr", detector_threshold, 2'h0);
    drop = 1'b1;
    cyc(6);
    chk("rearm", por_rearm, 1'b1);
    cyc(6);
    chk("rst", system_reset, 1'b0);
    drop = 1'b0;
    cyc(4);
    wr_reset_cause_register(16'h0000);
    deep_sleep_exit = 1'b1;
    cyc(1);
    deep_sleep_exit = 1'b0;
    cyc(1);
    chk("flags", core_rd.reset_cause_register[1:0], 2'h3);
    // mode 00: detection off entirely, soft bit reads zero
    boot(8'h20, 1'b1);
    drop = 1'b1;
    cyc(8);
    chk("en", detector_enable, 1'b0);
    chk("rst", system_reset, 1'b0);
    chk("rearm", por_rearm, 1'b0);
    chk("reset_cause_register", core_rd.reset_cause_register[13], 1'b0);
    drop = 1'b0;
    cyc(4);
  endtask

  initial begin
    t_reset_values();
    t_soft_mode();
    t_bor_delay();
    t_sleep();
    t_low_power();
    finish_test();
  end
endmodule
`default_nettype wire
